// ---- hdl/asp_top.sv ----
// async serial port: registers, bit-rate generator, tx/rx, infrared
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module asp_top (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // register port
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // serial line
  input  wire logic        ser_rx_in,
  output logic             ser_tx_out,
  input  wire logic        ir_rx_in,
  output logic             ir_tx_out,
  // interrupt
  output logic             irq_out
);

  // ===========================================================
  // helpers
  function automatic logic [2:0] last_bit(input logic [1:0] wlen);
    last_bit = 3'h4 + {1'b0, wlen};
  endfunction

  function automatic logic [4:0] lvl_count(input logic [2:0] sel);
    case (sel)
      3'h0:    lvl_count = 5'h02;
      3'h1:    lvl_count = 5'h04;
      3'h2:    lvl_count = 5'h08;
      3'h3:    lvl_count = 5'h0C;
      3'h4:    lvl_count = 5'h0E;
      default: lvl_count = 5'h08;
    endcase
  endfunction

  function automatic logic par_bit(input asp_pkg::asp_par_t p,
                                   input logic [7:0] d);
    case (p)
      asp_pkg::PAR_EVEN: par_bit = ^d;
      asp_pkg::PAR_ODD:  par_bit = ~^d;
      asp_pkg::PAR_ONE:  par_bit = 1'b1;
      default:           par_bit = 1'b0;
    endcase
  endfunction

  // ===========================================================
  // registers
  logic [15:0]             baud_div;
  asp_pkg::asp_lcr_t       lcr;
  asp_pkg::asp_ctl_t       ctl;
  logic [2:0]              tx_lvl;
  logic [2:0]              rx_lvl;
  logic [asp_pkg::NIRQ-1:0] irq_mask;
  logic [asp_pkg::NIRQ-1:0] irq_raw;
  logic [asp_pkg::NIRQ-1:0] irq_ev;

  wire wr_data = reg_wr_in && reg_addr_in == asp_pkg::OFF_DATA;
  wire rd_data = reg_rd_in && reg_addr_in == asp_pkg::OFF_DATA;
  wire rd_ris  = reg_rd_in && reg_addr_in == asp_pkg::OFF_RIS;
  wire wr_iclr = reg_wr_in && reg_addr_in == asp_pkg::OFF_ICLR;
  wire tx_en   = ctl.port_global_enable && ctl.transmit_enable;
  wire rx_en   = ctl.port_global_enable && ctl.receive_enable;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      baud_div <= asp_pkg::BAUD_RST;
      lcr      <= '0;
      ctl      <= '0;
      tx_lvl   <= asp_pkg::LVL_RST;
      rx_lvl   <= asp_pkg::LVL_RST;
      irq_mask <= '0;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        asp_pkg::OFF_BAUD: baud_div <= reg_wdata_in[15:0];
        asp_pkg::OFF_LCR:  lcr <= reg_wdata_in[6:0];
        asp_pkg::OFF_CTL:  ctl <= reg_wdata_in[5:0];
        asp_pkg::OFF_LVL:
        begin
          tx_lvl <= reg_wdata_in[2:0];
          rx_lvl <= reg_wdata_in[5:3];
        end
        asp_pkg::OFF_IMSK: irq_mask <= reg_wdata_in[6:0];
        default: ;
      endcase
    end
  end

  // ===========================================================
  // fifos
  logic [7:0]  tx_head;
  logic        tx_valid;
  logic        tx_rdy;
  logic        tx_pop;
  logic [4:0]  tx_cnt;
  logic [11:0] rx_head;
  logic [11:0] rx_entry;
  logic        rx_valid;
  logic        rx_rdy;
  logic        rx_push;
  logic [4:0]  rx_cnt;
  asp_pkg::asp_state_t tx_state;
  asp_pkg::asp_state_t rx_state;

  // fifo disabled behaves as a one-deep holding register
  wire tx_acc   = ctl.fifo_en ? tx_rdy : tx_cnt == 5'h00;
  wire rx_acc   = ctl.fifo_en ? rx_rdy : rx_cnt == 5'h00;
  // stalled character completes first, then the queue drops
  wire tx_flush = !ctl.port_global_enable &&
                  tx_state == asp_pkg::ST_IDLE;

  asp_fifo #(.W(asp_pkg::TX_W)) u_tx_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (wr_data && tx_acc),
    .in_ready_out  (tx_rdy),
    .in_data_in    (reg_wdata_in[7:0]),
    .out_valid_out (tx_valid),
    .out_ready_in  (tx_pop),
    .out_data_out  (tx_head),
    .flush_in      (tx_flush),
    .count_out     (tx_cnt)
  );

  asp_fifo #(.W(asp_pkg::RX_W)) u_rx_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (rx_push && rx_acc),
    .in_ready_out  (rx_rdy),
    .in_data_in    (rx_entry),
    .out_valid_out (rx_valid),
    .out_ready_in  (rd_data),
    .out_data_out  (rx_head),
    .flush_in      (1'b0),
    .count_out     (rx_cnt)
  );

  // ===========================================================
  // bit-rate generator: one tick per divisor+1 clocks, 16 per bit
  logic [15:0] div_cnt;
  // at or past the divisor: lowering it never strands a long count
  wire         tick = div_cnt >= baud_div;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      div_cnt <= '0;
    else
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  // ===========================================================
  // transmitter
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic       tx_par;
  logic       tx_stop2;
  logic       tx_line;
  wire        tx_end = tick && tx_sub == 4'hF;

  assign tx_pop = tx_state == asp_pkg::ST_IDLE && tick && tx_valid &&
                  tx_en;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_state <= asp_pkg::ST_IDLE;
      tx_sub   <= '0;
      tx_bit   <= '0;
      tx_shift <= '0;
      tx_par   <= 1'b0;
      tx_stop2 <= 1'b0;
    end
    else
    begin
      if (tick)
        tx_sub <= tx_state == asp_pkg::ST_IDLE ? 4'h0 : tx_sub + 4'h1;
      case (tx_state)
        asp_pkg::ST_IDLE:
          if (tx_pop)
          begin
            tx_state <= asp_pkg::ST_START;
            tx_shift <= tx_head;
            tx_par   <= par_bit(lcr.par, tx_head &
                        (8'hFF >> (2'h3 - lcr.wlen)));
            tx_bit   <= '0;
            tx_stop2 <= 1'b0;
          end
        asp_pkg::ST_START:
          if (tx_end)
            tx_state <= asp_pkg::ST_DATA;
        asp_pkg::ST_DATA:
          if (tx_end)
          begin
            tx_shift <= tx_shift >> 1;
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == last_bit(lcr.wlen))
              tx_state <= lcr.par == asp_pkg::PAR_NONE ?
                          asp_pkg::ST_STOP : asp_pkg::ST_PAR;
          end
        asp_pkg::ST_PAR:
          if (tx_end)
            tx_state <= asp_pkg::ST_STOP;
        asp_pkg::ST_STOP:
          if (tx_end)
          begin
            if (lcr.stop2 && !tx_stop2)
              tx_stop2 <= 1'b1;
            else
              tx_state <= asp_pkg::ST_IDLE;
          end
        default: tx_state <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  // break forces the line low; its length is software's job
  always_comb
  begin
    case (tx_state)
      asp_pkg::ST_START: tx_line = 1'b0;
      asp_pkg::ST_DATA:  tx_line = tx_shift[0];
      asp_pkg::ST_PAR:   tx_line = tx_par;
      default:           tx_line = 1'b1;
    endcase
    if (lcr.brk)
      tx_line = 1'b0;
  end

  // ===========================================================
  // infrared encode/decode
  logic [8:0] ir_lp_cnt;
  logic [4:0] ir_hold;
  wire        ir_on   = ctl.infrared_mode_enable;
  wire        ir_norm = !tx_line && tx_sub < 4'(asp_pkg::IR_NORM_TICKS);
  wire        ir_lp   = ir_lp_cnt != '0;
  wire        rx_line = ir_on ? !(ir_rx_in || ir_hold != '0) : ser_rx_in;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ir_lp_cnt  <= '0;
      ir_hold    <= '0;
      ser_tx_out <= 1'b1;
      ir_tx_out  <= 1'b0;
    end
    else
    begin
      // armed only in low-power mode, so no stale pulse on mode switch
      if (ir_on && ctl.infrared_low_power && tick && tx_sub == 4'h0 &&
          !tx_line)
        ir_lp_cnt <= 9'(asp_pkg::IR_LP_CYC);
      else if (ir_lp)
        ir_lp_cnt <= ir_lp_cnt - 9'h001;
      if (ir_rx_in)
        ir_hold <= 5'(asp_pkg::OVERSAMPLE);
      else if (tick && ir_hold != '0)
        ir_hold <= ir_hold - 5'h01;
      ser_tx_out <= ir_on ? 1'b1 : tx_line;
      ir_tx_out  <= ir_on && (ctl.infrared_low_power ?
                    ir_lp : ir_norm);
    end
  end

  // ===========================================================
  // receiver: start checked at mid-bit, then every 16 ticks
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic       rx_perr;
  wire        rx_smp = tick && rx_sub == 4'hF;

  assign rx_push  = rx_state == asp_pkg::ST_STOP && rx_smp;
  assign rx_entry = {!rx_acc, !rx_line && rx_shift == 8'h00, rx_perr,
                     !rx_line, rx_shift};

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_state <= asp_pkg::ST_IDLE;
      rx_sub   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_perr  <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_sub <= rx_state == asp_pkg::ST_IDLE ? 4'h0 : rx_sub + 4'h1;
      case (rx_state)
        asp_pkg::ST_IDLE:
          if (tick && rx_en && !rx_line)
            rx_state <= asp_pkg::ST_START;
        asp_pkg::ST_START:
          if (tick && rx_sub == 4'h7)
          begin
            rx_sub   <= '0;
            rx_bit   <= '0;
            rx_shift <= '0;
            rx_perr  <= 1'b0;
            rx_state <= rx_line ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
          end
        asp_pkg::ST_DATA:
          if (rx_smp)
          begin
            rx_shift[rx_bit] <= rx_line;
            rx_bit           <= rx_bit + 3'h1;
            if (rx_bit == last_bit(lcr.wlen))
              rx_state <= lcr.par == asp_pkg::PAR_NONE ?
                          asp_pkg::ST_STOP : asp_pkg::ST_PAR;
          end
        asp_pkg::ST_PAR:
          if (rx_smp)
          begin
            rx_perr  <= rx_line != par_bit(lcr.par, rx_shift);
            rx_state <= asp_pkg::ST_STOP;
          end
        asp_pkg::ST_STOP:
          if (rx_smp)
            rx_state <= asp_pkg::ST_IDLE;
        default: rx_state <= asp_pkg::ST_IDLE;
      endcase
    end
  end

  // ===========================================================
  // receive timeout: 32 bit times idle with data waiting
  logic [9:0] rto_cnt;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rto_cnt <= '0;
    else if (!rx_valid || rx_push || rd_data)
      rto_cnt <= '0;
    else if (tick && rto_cnt != 10'(asp_pkg::RTO_TICKS))
      rto_cnt <= rto_cnt + 10'h001;
  end

  // ===========================================================
  // interrupts
  logic tx_thr_q;
  logic rx_thr_q;
  wire  tx_thr = tx_cnt <= lvl_count(tx_lvl);
  wire  rx_thr = rx_cnt >= lvl_count(rx_lvl);
  wire [asp_pkg::NIRQ-1:0] irq_clr =
    (rd_ris ? {asp_pkg::NIRQ{1'b1}} : '0) |
    (wr_iclr ? reg_wdata_in[6:0] : '0);

  always_comb
  begin
    irq_ev                   = '0;
    irq_ev[asp_pkg::IRQ_RX]  = rx_thr && !rx_thr_q;
    irq_ev[asp_pkg::IRQ_TX]  = tx_thr && !tx_thr_q;
    irq_ev[asp_pkg::IRQ_RT]  = tick &&
                               rto_cnt == 10'(asp_pkg::RTO_TICKS - 1);
    irq_ev[asp_pkg::IRQ_FE]  = rx_push && rx_entry[8];
    irq_ev[asp_pkg::IRQ_PE]  = rx_push && rx_entry[9];
    irq_ev[asp_pkg::IRQ_BE]  = rx_push && rx_entry[10];
    irq_ev[asp_pkg::IRQ_OE]  = rx_push && !rx_acc;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_raw  <= '0;
      tx_thr_q <= 1'b1;
      rx_thr_q <= 1'b0;
    end
    else
    begin
      irq_raw  <= (irq_raw & ~irq_clr) | irq_ev;
      tx_thr_q <= tx_thr;
      rx_thr_q <= rx_thr;
    end
  end

  assign irq_out = |(irq_raw & irq_mask);

  // ===========================================================
  // read port: data one cycle after the strobe, zero otherwise
  logic [31:0] rd_mux;

  always_comb
  begin
    case (reg_addr_in)
      asp_pkg::OFF_DATA: rd_mux = {20'h00000, rx_valid ? rx_head : 12'h000};
      asp_pkg::OFF_FLAG: rd_mux = {27'h0000000, tx_cnt == 5'h00, !rx_acc,
                                   !tx_acc, !rx_valid,
                                   tx_state != asp_pkg::ST_IDLE};
      asp_pkg::OFF_BAUD: rd_mux = {16'h0000, baud_div};
      asp_pkg::OFF_LCR:  rd_mux = {25'h0000000, lcr};
      asp_pkg::OFF_CTL:  rd_mux = {26'h0000000, ctl};
      asp_pkg::OFF_LVL:  rd_mux = {26'h0000000, rx_lvl, tx_lvl};
      asp_pkg::OFF_IMSK: rd_mux = {25'h0000000, irq_mask};
      asp_pkg::OFF_RIS:  rd_mux = {25'h0000000, irq_raw};
      asp_pkg::OFF_MIS:  rd_mux = {25'h0000000, irq_raw & irq_mask};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reg_rdata_out <= '0;
    else
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
  end

endmodule

// ---- hdl/asp_pkg.sv ----
// shared constants, types and register map of the async serial port
package asp_pkg;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int IR_LP_PULSE_NS = 1630;
  localparam int IR_LP_CYC      =
    (IR_LP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERSAMPLE     = 16;
  localparam int RTO_BITS       = 32;
  localparam int RTO_TICKS      = RTO_BITS * OVERSAMPLE;
  localparam int IR_NORM_TICKS  = 3;

  // ===========================================================
  // fifo geometry
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int CNT_W      = 5;
  localparam int TX_W       = 8;
  localparam int RX_W       = 12;

  // ===========================================================
  // register byte offsets
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_FLAG = 6'h04;
  localparam logic [5:0] OFF_BAUD = 6'h08;
  localparam logic [5:0] OFF_LCR  = 6'h0C;
  localparam logic [5:0] OFF_CTL  = 6'h10;
  localparam logic [5:0] OFF_LVL  = 6'h14;
  localparam logic [5:0] OFF_IMSK = 6'h18;
  localparam logic [5:0] OFF_RIS  = 6'h1C;
  localparam logic [5:0] OFF_MIS  = 6'h20;
  localparam logic [5:0] OFF_ICLR = 6'h24;

  // ===========================================================
  // field positions and reset values
  localparam int FLG_BUSY = 0;
  localparam int FLG_RXE  = 1;
  localparam int FLG_TXF  = 2;
  localparam int FLG_RXF  = 3;
  localparam int FLG_TXE  = 4;
  localparam int NIRQ     = 7;
  localparam int IRQ_RX   = 0;
  localparam int IRQ_TX   = 1;
  localparam int IRQ_RT   = 2;
  localparam int IRQ_FE   = 3;
  localparam int IRQ_PE   = 4;
  localparam int IRQ_BE   = 5;
  localparam int IRQ_OE   = 6;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [2:0]  LVL_RST  = 3'h2;

  // ===========================================================
  // types
  typedef enum logic [2:0] {
    PAR_NONE = 3'h0,
    PAR_EVEN = 3'h1,
    PAR_ODD  = 3'h2,
    PAR_ONE  = 3'h3,
    PAR_ZERO = 3'h4
  } asp_par_t;

  typedef struct packed {
    logic     brk;
    asp_par_t par;
    logic     stop2;
    logic [1:0] wlen;
  } asp_lcr_t;

  typedef struct packed {
    logic infrared_low_power;
    logic infrared_mode_enable;
    logic fifo_en;
    logic receive_enable;
    logic transmit_enable;
    logic port_global_enable;
  } asp_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_PAR   = 3'h3,
    ST_STOP  = 3'h4
  } asp_state_t;

endpackage

// ---- hdl/asp_fifo.sv ----
// sixteen-entry synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module asp_fifo #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  // fill side
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [W-1:0]               in_data_in,
  // drain side
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic [W-1:0]                    out_data_out,
  // control and level
  input  wire logic                       flush_in,
  output logic [asp_pkg::CNT_W-1:0]       count_out
);

  logic [W-1:0]               mem [asp_pkg::FIFO_DEPTH];
  logic [asp_pkg::PTR_W-1:0]  wr_ptr;
  logic [asp_pkg::PTR_W-1:0]  rd_ptr;
  logic [asp_pkg::CNT_W-1:0]  cnt;
  wire                        push;
  wire                        pop;

  assign in_ready_out  = cnt != asp_pkg::CNT_W'(asp_pkg::FIFO_DEPTH);
  assign out_valid_out = cnt != '0;
  assign push          = in_valid_in && in_ready_out && !flush_in;
  assign pop           = out_valid_out && out_ready_in && !flush_in;
  assign out_data_out  = mem[rd_ptr];
  assign count_out     = cnt;

  always_ff @(posedge core_clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + PTR_ONE(push);
      rd_ptr <= rd_ptr + PTR_ONE(pop);
      cnt    <= cnt + CNT_ONE(push) - CNT_ONE(pop);
    end
  end

  function automatic logic [asp_pkg::PTR_W-1:0] PTR_ONE(input logic b);
    PTR_ONE = {{(asp_pkg::PTR_W-1){1'b0}}, b};
  endfunction

  function automatic logic [asp_pkg::CNT_W-1:0] CNT_ONE(input logic b);
    CNT_ONE = {{(asp_pkg::CNT_W-1){1'b0}}, b};
  endfunction

endmodule

// ---- dv/asp_chk.sv ----
// concurrent checks on the serial port's register and line outputs
`timescale 1ns/1ps
module asp_chk (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // register port
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_rdata_out,
  // line and interrupt
  input  wire logic        ser_tx_out,
  input  wire logic        ir_tx_out,
  input  wire logic        irq_out
);
  // ==========
  // shadows of the written control registers
  logic [6:0] mask;
  logic [6:0] lcr;
  logic [5:0] ctl;
  wire        wr_msk = reg_wr_in && reg_addr_in == asp_pkg::OFF_IMSK;
  wire        wr_lcr = reg_wr_in && reg_addr_in == asp_pkg::OFF_LCR;
  wire        wr_ctl = reg_wr_in && reg_addr_in == asp_pkg::OFF_CTL;
  wire        wr_clr = reg_wr_in && reg_addr_in == asp_pkg::OFF_ICLR;
  wire        rd_lcr = reg_rd_in && reg_addr_in == asp_pkg::OFF_LCR;
  wire        rd_ctl = reg_rd_in && reg_addr_in == asp_pkg::OFF_CTL;
  wire        rd_mis = reg_rd_in && reg_addr_in == asp_pkg::OFF_MIS;
  wire [6:0]  next_mask = wr_msk ? reg_wdata_in[6:0] : mask;
  wire [6:0]  next_lcr = wr_lcr ? reg_wdata_in[6:0] : lcr;
  wire [5:0]  next_ctl = wr_ctl ? reg_wdata_in[5:0] : ctl;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mask <= '0;
      lcr <= '0;
      ctl <= '0;
    end
    else
    begin
      mask <= next_mask;
      lcr <= next_lcr;
      ctl <= next_ctl;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ==========
  // properties
  a_rdata_slot:
    assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside its slot");
  a_lcr_back:
    assert property ($past(rd_lcr) |-> reg_rdata_out == {25'h0, lcr})
      else $error("frame format read back differs");
  a_ctl_back:
    assert property ($past(rd_ctl) |-> reg_rdata_out == {26'h0, ctl})
      else $error("control read back differs");
  a_irq_masked:
    assert property (mask == 7'h0 |-> !irq_out)
      else $error("interrupt with all sources masked");
  a_mis_subset:
    assert property ($past(rd_mis) |->
      (reg_rdata_out & ~{25'h0, $past(mask)}) == 32'h0)
      else $error("masked status shows a masked source");
  a_irq_mis:
    assert property ($past(rd_mis) |->
      (reg_rdata_out != 32'h0) == $past(irq_out))
      else $error("interrupt line disagrees with masked status");
  a_clear_drop:
    assert property (wr_clr && (reg_wdata_in[6:0] & mask) == mask
      |=> !irq_out)
      else $error("interrupt stays after clearing");
  a_start_len:
    assert property ($fell(ser_tx_out) && !ctl[4] && !lcr[6]
      |-> (!ser_tx_out) [*8])
      else $error("start bit too short");
  a_ir_line_high:
    assert property (ctl[4] && $past(ctl[4]) |-> ser_tx_out)
      else $error("serial line not idle in infrared mode");
  a_ir_off_low:
    assert property (!ctl[4] && !$past(ctl[4]) && !$past(ctl[4], 2)
      |-> !ir_tx_out)
      else $error("infrared pulse with infrared off");
endmodule

bind asp_top asp_chk u_asp_chk (
  .core_clk_in  (core_clk_in),
  .resetn_in    (resetn_in),
  .reg_addr_in  (reg_addr_in),
  .reg_wdata_in (reg_wdata_in),
  .reg_wr_in    (reg_wr_in),
  .reg_rd_in    (reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .ser_tx_out   (ser_tx_out),
  .ir_tx_out    (ir_tx_out),
  .irq_out      (irq_out)
);

// ---- dv/asp_far_end.sv ----
// far-end serial device: captures sent frames, sends frames to the port
`timescale 1ns/1ps
module asp_far_end (
  // clock
  input  wire logic clk_in,
  // serial line
  input  wire logic line_in,
  output logic      line_out
);
  // ==========
  // capture, sampled mid-bit
  int          bit_clks = 16;
  int          nb = 9;
  logic [11:0] cap;
  logic [11:0] caps[$];

  initial line_out = 1'b1;

  always
  begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    cap = '1;
    if (line_in === 1'b0)
    begin
      for (int i = 0; i < nb; i++)
      begin
        repeat (bit_clks) @(posedge clk_in);
        cap[i] = line_in;
      end
      caps.push_back(cap);
    end
  end

  // ==========
  // sender; the line idles high between frames
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask
endmodule

// ---- dv/tb.sv ----
// testbench: register, frame, interrupt and infrared scenarios
`timescale 1ns/1ps
module tb;
  // ==========
  // hookup
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [5:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        rx, tx, irtx, irq;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          ir_high = 0;
  int          h, w, p, n;
  logic        s2;
  logic [7:0]  d;
  logic [31:0] rv;
  logic [11:0] f;

  always #2.5 core_clk = ~core_clk;

  asp_top dut (
    .core_clk_in  (core_clk),
    .resetn_in    (resetn),
    .reg_addr_in  (addr),
    .reg_wdata_in (wdata),
    .reg_wr_in    (wr),
    .reg_rd_in    (rd),
    .reg_rdata_out(rdata),
    .ser_rx_in    (rx),
    .ser_tx_out   (tx),
    .ir_rx_in     (1'b0),
    .ir_tx_out    (irtx),
    .irq_out      (irq)
  );
  asp_far_end far (.clk_in(core_clk), .line_in(tx), .line_out(rx));

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    ir_high <= ir_high + int'(irtx);
    if (cycles == 60000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ==========
  // access and compare
  task automatic put(input logic [5:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic get(input logic [5:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = '1);
    get(a);
    cmp(rv & m, e);
  endtask

  task automatic wait_caps(input int k);
    for (int i = 0; i < 5000 && far.caps.size() < k; i++)
      @(posedge core_clk);
  endtask

  task automatic wait_rx;
    rv = '1;
    for (int i = 0; i < 500 && rv[asp_pkg::FLG_RXE] !== 1'b0; i++)
      get(asp_pkg::OFF_FLAG);
  endtask

  // bits after the start bit; stop bits and idle stay high
  function automatic logic [11:0] frame(logic [7:0] v, int wl, int pm);
    logic [11:0] b;
    logic        x;
    b = 12'hFFF;
    x = ^(v & (8'hFF >> (3 - wl)));
    for (int i = 0; i < wl + 5; i++)
      b[i] = v[i];
    if (pm != 0)
      b[wl + 5] = (pm == 1) ? x : (pm == 2) ? ~x : (pm == 3);
    return b;
  endfunction

  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========
  // scenarios
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(asp_pkg::OFF_LVL, 32'h12);
    chk(asp_pkg::OFF_RIS, 32'h0);
    chk(6'h3C, 32'h0);
    put(asp_pkg::OFF_CTL, 32'h0F);
    chk(asp_pkg::OFF_CTL, 32'h0F);
    for (int c = 0; c < 40; c++)
    begin
      w = c % 4;
      p = (c / 4) % 5;
      s2 = c >= 20;
      d = 8'(8'h5A + c * 37);
      n = w + 6 + int'(p != 0) + int'(s2);
      far.nb = n;
      put(asp_pkg::OFF_LCR, 32'(p * 8 + int'(s2) * 4 + w));
      chk(asp_pkg::OFF_LCR, 32'(p * 8 + int'(s2) * 4 + w));
      put(asp_pkg::OFF_DATA, 32'(d));
      put(asp_pkg::OFF_DATA, 32'(~d));
      wait_caps(2);
      cmp(32'(far.caps.pop_front()), 32'(frame(d, w, p)));
      cmp(32'(far.caps.pop_front()), 32'(frame(~d, w, p)));
      far.send(frame(d, w, p), n);
      wait_rx;
      chk(asp_pkg::OFF_DATA, 32'(d & (8'hFF >> (3 - w))));
    end
    put(asp_pkg::OFF_LCR, 32'h03);
    far.nb = 9;
    put(asp_pkg::OFF_BAUD, 32'h1);
    chk(asp_pkg::OFF_BAUD, 32'h1);
    far.bit_clks = 32;
    put(asp_pkg::OFF_DATA, 32'h3C);
    wait_caps(1);
    cmp(32'(far.caps.pop_front()), 32'(frame(8'h3C, 3, 0)));
    repeat (32) @(posedge core_clk);
    far.bit_clks = 16;
    put(asp_pkg::OFF_BAUD, 32'h0);
    put(asp_pkg::OFF_LCR, 32'h0B);
    put(asp_pkg::OFF_ICLR, 32'h7F);
    f = frame(8'h31, 3, 1);
    far.send(f ^ 12'h100, 10);
    wait_rx;
    cmp(32'(irq), 32'h0);
    put(asp_pkg::OFF_IMSK, 32'h10);
    cmp(32'(irq), 32'h1);
    chk(asp_pkg::OFF_MIS, 32'h10);
    chk(asp_pkg::OFF_DATA, 32'h231);
    put(asp_pkg::OFF_ICLR, 32'h10);
    cmp(32'(irq), 32'h0);
    far.send(12'h000, 10);
    wait_rx;
    chk(asp_pkg::OFF_DATA, 32'h500, 32'hDFF);
    put(asp_pkg::OFF_LVL, 32'h0);
    put(asp_pkg::OFF_ICLR, 32'h7F);
    far.send(f, 10);
    chk(asp_pkg::OFF_RIS, 32'h0, 32'h1);
    far.send(f, 10);
    chk(asp_pkg::OFF_RIS, 32'h1, 32'h1);
    get(asp_pkg::OFF_DATA);
    get(asp_pkg::OFF_DATA);
    put(asp_pkg::OFF_LCR, 32'h03);
    far.nb = 9;
    put(asp_pkg::OFF_DATA, 32'h11);
    put(asp_pkg::OFF_DATA, 32'h22);
    for (int i = 0; i < 100 && tx !== 1'b0; i++)
      @(posedge core_clk);
    put(asp_pkg::OFF_CTL, 32'h0);
    repeat (400) @(posedge core_clk);
    cmp(32'(far.caps.size()), 32'h1);
    cmp(32'(far.caps.pop_front()), 32'(frame(8'h11, 3, 0)));
    chk(asp_pkg::OFF_FLAG, 32'h12, 32'h17);
    put(asp_pkg::OFF_CTL, 32'h1F);
    h = ir_high;
    put(asp_pkg::OFF_DATA, 32'h0);
    repeat (250) @(posedge core_clk);
    cmp(32'(ir_high - h), 32'h1B);
    put(asp_pkg::OFF_CTL, 32'h3F);
    h = ir_high;
    put(asp_pkg::OFF_DATA, 32'hFF);
    repeat (450) @(posedge core_clk);
    cmp(32'(ir_high - h), 32'(asp_pkg::IR_LP_CYC));
    put(asp_pkg::OFF_CTL, 32'h0F);
    put(asp_pkg::OFF_DATA, 32'h55);
    wait_caps(1);
    cmp(32'(far.caps.pop_front()), 32'(frame(8'h55, 3, 0)));
    put(asp_pkg::OFF_LCR, 32'h43);
    repeat (320) @(posedge core_clk);
    cmp(32'(tx), 32'h0);
    put(asp_pkg::OFF_LCR, 32'h03);
    cmp(32'(far.caps.pop_front()), 32'hE00);
    tally_and_finish();
  end
endmodule
